// >>> rtl/mie_pkg.sv
package mie_pkg;

  // ****************************************************************
  // Widths and field positions
  // ****************************************************************
  localparam int WORD_W = 16;
  localparam int AP_W = 6;
  localparam int SV_W = 4;
  localparam int STR_W = 8;
  localparam int FIVE_BIT_IMMEDIATE_W = 5;
  localparam int ACC_N = 4;
  localparam int ACC_SEL_W = 2;
  localparam int ACC_FILE_W = 64;
  localparam int ACC_IDX_W = 6;
  localparam int FLAG_IDX_W = 4;

  // Status register bit positions
  localparam int STAT_ZF_BIT = 0;
  localparam int STAT_UM_BIT = 1;
  localparam int STAT_SF_BIT = 2;
  localparam int STAT_TF1_BIT = 3;
  localparam int STAT_TF2_BIT = 4;

  // ****************************************************************
  // Reset values and bus constants
  // ****************************************************************
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [5:0] AP_RST = 6'h00;
  localparam logic [3:0] SV_RST = 4'h0;
  localparam logic [7:0] STR_RST = 8'h00;
  localparam logic [15:0] UNMAPPED_RD = 16'h0000;

  // Register bus word offsets (byte addresses)
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MR = 8'h08;
  localparam logic [7:0] REG_SV = 8'h0C;
  localparam logic [7:0] REG_STR = 8'h10;
  localparam logic [7:0] REG_TOS = 8'h14;
  localparam logic [7:0] REG_DP = 8'h18;
  localparam logic [7:0] REG_PH = 8'h1C;
  localparam logic [7:0] REG_AP = 8'h20;

  // ****************************************************************
  // Move operations
  // ****************************************************************
  typedef enum logic [4:0] {
    OP_NOP        = 5'h00,
    OP_ACC_DM     = 5'h01,
    OP_DM_ACC     = 5'h02,
    OP_ACC_IMM    = 5'h03,
    OP_MR_IMM     = 5'h04,
    OP_ACC_PAIR   = 5'h05,
    OP_ACC_PH     = 5'h06,
    OP_SV_ACC     = 5'h07,
    OP_PH_ACC     = 5'h08,
    OP_MR_ACC     = 5'h09,
    OP_ACC_PM     = 5'h0A,
    OP_PH_DM      = 5'h0B,
    OP_MR_DM      = 5'h0C,
    OP_DM_PM      = 5'h0D,
    OP_AP_DM      = 5'h0E,
    OP_STAT_DM    = 5'h0F,
    OP_SV_DM      = 5'h10,
    OP_TOS_DM     = 5'h11,
    OP_DM_SPECIAL = 5'h12,
    OP_STR_DM     = 5'h13,
    OP_TF_FLAG    = 5'h14,
    OP_FLAG_TF    = 5'h15,
    OP_TF_COND    = 5'h16,
    OP_SV_IMM     = 5'h17,
    OP_STR_IMM    = 5'h18,
    OP_AP_IMM     = 5'h19
  } mie_op_t;

  // Special register source for stores
  typedef enum logic [2:0] {
    SRC_PH   = 3'h0,
    SRC_MR   = 3'h1,
    SRC_STAT = 3'h2,
    SRC_STR  = 3'h3,
    SRC_DP   = 3'h4,
    SRC_SV   = 3'h5,
    SRC_AP   = 3'h6,
    SRC_TOS  = 3'h7
  } mie_src_t;

  // Pointer premodification
  typedef enum logic [1:0] {
    PRE_NONE = 2'h0,
    PRE_INC  = 2'h1,
    PRE_DEC  = 2'h2
  } mie_pre_t;

  // Execution sequencer
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_READ  = 2'h1,
    ST_WRITE = 2'h2
  } mie_state_t;

endpackage : mie_pkg

// >>> rtl/mie_move_exec.sv
`timescale 1ns/1ps
// Behaviour
// RULE_01: Optional pointer pre-increment or pre-decrement; access uses new pointer.
// RULE_02: Loading an accumulator or its pair updates accumulator flags.
// RULE_03: Accumulator to shift amount moves only the low four bits.
// RULE_04: Accumulator to multiplier operand also selects signed mode.
// RULE_05: Data word to multiplier operand loads it and selects signed mode.
// RULE_06: Signed mode clears the unsigned-multiply status bit one.
// RULE_07: Pointer load from data memory keeps the low six bits.
// RULE_08: Shift amount load from data memory keeps the low four bits.
// RULE_09: Storing shift amount writes its four-bit value to memory.
// RULE_10: String length loads a byte from data memory.
// RULE_11: Storing string length writes its byte to memory.
// RULE_12: String length loads from the eight-bit immediate.
// RULE_13: Pointer loads from the five-bit immediate.
// RULE_14: Test flag takes one for true condition, zero otherwise.
// RULE_15: Test flag stores into a memory flag at index plus offset.
// RULE_16: Accumulator-indirect source reads program memory into an accumulator.
// RULE_17: Program word addressed by accumulator copies to data memory.
// RULE_18: Whole status register loads from a data word.
// RULE_19: Stack top is written from a data word.
// RULE_20: Stack top is read into a data word.
// RULE_21: Accumulator and paired offset accumulator copy either way.
// RULE_22: Multiplier operand loads from a sixteen-bit immediate.
// RULE_23: Non-accumulator destinations leave accumulator flags unchanged.
module mie_move_exec (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [15:0] dm_addr,
  output logic dm_read,
  output logic dm_write,
  output logic [15:0] dm_wdata,
  input wire logic [15:0] dm_rdata,
  output logic [15:0] pm_addr,
  output logic pm_read,
  input wire logic [15:0] pm_rdata,
  input wire logic [15:0] index_register_five,
  input wire logic test_condition
);

  // ****************************************************************
  // Reset synchroniser
  // ****************************************************************
  logic rst_s1_q;
  logic rst_n_q;

  // Two-stage release of reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Pointer after optional premodification
  function automatic logic [5:0] pre_mod(input logic [5:0] p,
                                         input logic [1:0] m);
    case (m)
      mie_pkg::PRE_INC: pre_mod = p + 6'h01;
      mie_pkg::PRE_DEC: pre_mod = p - 6'h01;
      default: pre_mod = p;
    endcase
  endfunction : pre_mod

  // Physical accumulator index, pair bit selects the offset bank
  function automatic logic [5:0] acc_idx(input logic [5:0] p,
                                         input logic pair);
    acc_idx = {p[5:1], p[0] ^ pair};
  endfunction : acc_idx

  // ****************************************************************
  // State
  // ****************************************************************
  logic [15:0] acc_q [64];
  logic [15:0] acc_d [64];
  logic [5:0] ap_q [4];
  logic [5:0] ap_d [4];
  logic [15:0] mr_q, mr_d, ph_q, ph_d, tos_q, tos_d, dp_q, dp_d;
  logic [15:0] stat_q, stat_d;
  logic [3:0] sv_q, sv_d;
  logic [7:0] str_q, str_d;
  logic [31:0] cmd_q, cmd_d;
  logic [5:0] ptr_q, ptr_d;
  mie_pkg::mie_state_t st_q, st_d;
  logic [31:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic [15:0] dm_addr_q, dm_addr_d, dm_wdata_q, dm_wdata_d;
  logic dm_read_q, dm_read_d, dm_write_q, dm_write_d;
  logic [15:0] pm_addr_q, pm_addr_d;
  logic pm_read_q, pm_read_d;

  // Command word fields
  mie_pkg::mie_op_t op;
  logic [1:0] asel, pre;
  logic pair;
  logic [2:0] src;
  logic [15:0] imm;
  logic [5:0] p;
  logic [15:0] av;
  logic wr_hit, rd_hit, busy;

  assign op = mie_pkg::mie_op_t'(cmd_q[4:0]);
  assign asel = cmd_q[6:5];
  assign pre = cmd_q[8:7];
  assign pair = cmd_q[9];
  assign src = cmd_q[12:10];
  assign imm = cmd_q[31:16];
  assign p = ptr_q;
  assign av = acc_q[acc_idx(p, pair)];
  assign busy = (st_q != mie_pkg::ST_IDLE);
  assign wr_hit = avs_write && !busy;
  assign rd_hit = avs_read && !rvalid_q;

  // Bus waits while a move runs or a read answer is being formed
  assign avs_waitrequest = (avs_write && busy) || (avs_read && !rvalid_q);
  assign avs_readdata = rdata_q;
  assign dm_addr = dm_addr_q;
  assign dm_read = dm_read_q;
  assign dm_write = dm_write_q;
  assign dm_wdata = dm_wdata_q;
  assign pm_addr = pm_addr_q;
  assign pm_read = pm_read_q;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Sequencer, bus slave and move execution
  always_comb begin
    logic [15:0] ld;
    logic ld_acc;
    ld = 16'h0000;
    ld_acc = 1'b0;
    acc_d = acc_q;
    ap_d = ap_q;
    mr_d = mr_q;
    ph_d = ph_q;
    tos_d = tos_q;
    dp_d = dp_q;
    stat_d = stat_q;
    sv_d = sv_q;
    str_d = str_q;
    cmd_d = cmd_q;
    ptr_d = ptr_q;
    st_d = st_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    dm_addr_d = dm_addr_q;
    dm_wdata_d = dm_wdata_q;
    dm_read_d = 1'b0;
    dm_write_d = 1'b0;
    pm_addr_d = pm_addr_q;
    pm_read_d = 1'b0;
    if (rd_hit) begin
      rvalid_d = 1'b1;
      case (avs_address)
        mie_pkg::REG_CMD: rdata_d = cmd_q;
        mie_pkg::REG_STATUS: rdata_d = {14'h0000, busy, 1'b0, stat_q};
        mie_pkg::REG_MR: rdata_d = {16'h0000, mr_q};
        mie_pkg::REG_SV: rdata_d = {28'h0000000, sv_q};
        mie_pkg::REG_STR: rdata_d = {24'h000000, str_q};
        mie_pkg::REG_TOS: rdata_d = {16'h0000, tos_q};
        mie_pkg::REG_DP: rdata_d = {16'h0000, dp_q};
        mie_pkg::REG_PH: rdata_d = {16'h0000, ph_q};
        mie_pkg::REG_AP: rdata_d = {2'h0, ap_q[3], 2'h0, ap_q[2],
                                    2'h0, ap_q[1], 2'h0, ap_q[0]};
        default: rdata_d = {16'h0000, mie_pkg::UNMAPPED_RD};
      endcase
    end
    case (st_q)
      mie_pkg::ST_IDLE: begin
        if (wr_hit && avs_address == mie_pkg::REG_CMD &&
            avs_byteenable == 4'hF) begin
          cmd_d = avs_writedata;
          ptr_d = pre_mod(ap_q[avs_writedata[6:5]],
                          avs_writedata[8:7]); // RULE_01
          ap_d[avs_writedata[6:5]] = ptr_d; // RULE_01
          st_d = mie_pkg::ST_READ;
        end else if (wr_hit && avs_address == mie_pkg::REG_DP) begin
          dp_d = avs_writedata[15:0];
        end
      end
      mie_pkg::ST_READ: begin
        // Fetch operands: data address in imm, pm address from accumulator
        st_d = mie_pkg::ST_WRITE;
        dm_addr_d = imm;
        case (op)
          mie_pkg::OP_ACC_DM, mie_pkg::OP_PH_DM, mie_pkg::OP_MR_DM,
          mie_pkg::OP_AP_DM, mie_pkg::OP_STAT_DM, mie_pkg::OP_SV_DM,
          mie_pkg::OP_TOS_DM, mie_pkg::OP_STR_DM,
          mie_pkg::OP_TF_FLAG: dm_read_d = 1'b1;
          mie_pkg::OP_ACC_PM, mie_pkg::OP_DM_PM: begin
            pm_addr_d = av; // RULE_16 RULE_17
            pm_read_d = 1'b1;
          end
          mie_pkg::OP_FLAG_TF: begin
            dm_addr_d = index_register_five + imm; // RULE_15
            dm_wdata_d = {15'h0000, stat_q[mie_pkg::STAT_TF1_BIT]};
            dm_write_d = 1'b1; // RULE_15
          end
          default: ;
        endcase
      end
      mie_pkg::ST_WRITE: begin
        st_d = mie_pkg::ST_IDLE;
        case (op)
          mie_pkg::OP_ACC_DM: begin
            ld = dm_rdata;
            ld_acc = 1'b1;
          end
          mie_pkg::OP_DM_ACC: begin
            dm_addr_d = imm;
            dm_wdata_d = av;
            dm_write_d = 1'b1;
          end
          mie_pkg::OP_ACC_IMM: begin
            ld = imm;
            ld_acc = 1'b1;
          end
          mie_pkg::OP_MR_IMM: mr_d = imm; // RULE_22
          mie_pkg::OP_ACC_PAIR: begin
            ld = acc_q[acc_idx(p, 1'b1 ^ pair)]; // RULE_21
            ld_acc = 1'b1;
          end
          mie_pkg::OP_ACC_PH: begin
            ld = ph_q;
            ld_acc = 1'b1;
          end
          mie_pkg::OP_SV_ACC: sv_d = av[3:0]; // RULE_03
          mie_pkg::OP_PH_ACC: ph_d = av;
          mie_pkg::OP_MR_ACC: begin
            mr_d = av;
            stat_d[mie_pkg::STAT_UM_BIT] = 1'b0; // RULE_04 RULE_06
          end
          mie_pkg::OP_ACC_PM: begin
            ld = pm_rdata; // RULE_16
            ld_acc = 1'b1;
          end
          mie_pkg::OP_PH_DM: ph_d = dm_rdata;
          mie_pkg::OP_MR_DM: begin
            mr_d = dm_rdata;
            stat_d[mie_pkg::STAT_UM_BIT] = 1'b0; // RULE_05 RULE_06
          end
          mie_pkg::OP_DM_PM: begin
            dm_addr_d = imm;
            dm_wdata_d = pm_rdata; // RULE_17
            dm_write_d = 1'b1;
          end
          mie_pkg::OP_AP_DM: ap_d[asel] = dm_rdata[5:0]; // RULE_07
          mie_pkg::OP_STAT_DM: stat_d = dm_rdata; // RULE_18
          mie_pkg::OP_SV_DM: sv_d = dm_rdata[3:0]; // RULE_08
          mie_pkg::OP_TOS_DM: tos_d = dm_rdata; // RULE_19
          mie_pkg::OP_STR_DM: str_d = dm_rdata[7:0]; // RULE_10
          mie_pkg::OP_TF_FLAG:
            stat_d[mie_pkg::STAT_TF1_BIT] = dm_rdata[0];
          mie_pkg::OP_TF_COND:
            stat_d[mie_pkg::STAT_TF1_BIT] = test_condition; // RULE_14
          mie_pkg::OP_SV_IMM: sv_d = imm[3:0];
          mie_pkg::OP_STR_IMM: str_d = imm[7:0]; // RULE_12
          mie_pkg::OP_AP_IMM: ap_d[asel] = {1'b0, imm[4:0]}; // RULE_13
          mie_pkg::OP_DM_SPECIAL: begin
            dm_addr_d = imm;
            dm_write_d = 1'b1;
            case (mie_pkg::mie_src_t'(src))
              mie_pkg::SRC_PH: dm_wdata_d = ph_q;
              mie_pkg::SRC_MR: dm_wdata_d = mr_q;
              mie_pkg::SRC_STAT: dm_wdata_d = stat_q;
              mie_pkg::SRC_STR: dm_wdata_d = {8'h00, str_q}; // RULE_11
              mie_pkg::SRC_DP: dm_wdata_d = dp_q;
              mie_pkg::SRC_SV: dm_wdata_d = {12'h000, sv_q}; // RULE_09
              mie_pkg::SRC_AP: dm_wdata_d = {10'h000, ap_q[asel]};
              mie_pkg::SRC_TOS: dm_wdata_d = tos_q; // RULE_20
              default: dm_wdata_d = 16'h0000;
            endcase
          end
          default: ;
        endcase
        // Flags follow only accumulator loads
        if (ld_acc) begin // RULE_23
          acc_d[acc_idx(p, pair)] = ld;
          stat_d[mie_pkg::STAT_ZF_BIT] = (ld == 16'h0000); // RULE_02
          stat_d[mie_pkg::STAT_SF_BIT] = ld[15]; // RULE_02
        end
      end
      default: st_d = mie_pkg::ST_IDLE;
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // State update under clock enable
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < mie_pkg::ACC_FILE_W; i++) begin
        acc_q[i] <= mie_pkg::WORD_RST;
      end
      for (int i = 0; i < mie_pkg::ACC_N; i++) begin
        ap_q[i] <= mie_pkg::AP_RST;
      end
      mr_q <= mie_pkg::WORD_RST;
      ph_q <= mie_pkg::WORD_RST;
      tos_q <= mie_pkg::WORD_RST;
      dp_q <= mie_pkg::WORD_RST;
      stat_q <= mie_pkg::WORD_RST;
      sv_q <= mie_pkg::SV_RST;
      str_q <= mie_pkg::STR_RST;
      cmd_q <= 32'h00000000;
      ptr_q <= mie_pkg::AP_RST;
      st_q <= mie_pkg::ST_IDLE;
      rdata_q <= 32'h00000000;
      rvalid_q <= 1'b0;
      dm_addr_q <= mie_pkg::WORD_RST;
      dm_wdata_q <= mie_pkg::WORD_RST;
      dm_read_q <= 1'b0;
      dm_write_q <= 1'b0;
      pm_addr_q <= mie_pkg::WORD_RST;
      pm_read_q <= 1'b0;
    end else if (clk_en) begin
      acc_q <= acc_d;
      ap_q <= ap_d;
      mr_q <= mr_d;
      ph_q <= ph_d;
      tos_q <= tos_d;
      dp_q <= dp_d;
      stat_q <= stat_d;
      sv_q <= sv_d;
      str_q <= str_d;
      cmd_q <= cmd_d;
      ptr_q <= ptr_d;
      st_q <= st_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      dm_addr_q <= dm_addr_d;
      dm_wdata_q <= dm_wdata_d;
      dm_read_q <= dm_read_d;
      dm_write_q <= dm_write_d;
      pm_addr_q <= pm_addr_d;
      pm_read_q <= pm_read_d;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sv_low_bits_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    (clk_en && st_q == mie_pkg::ST_WRITE && op == mie_pkg::OP_SV_ACC)
    |=> sv_q == $past(av[3:0])) // RULE_03
    else $error("shift amount not low four bits");
  mr_signed_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    (clk_en && st_q == mie_pkg::ST_WRITE &&
     (op == mie_pkg::OP_MR_ACC || op == mie_pkg::OP_MR_DM))
    |=> !stat_q[mie_pkg::STAT_UM_BIT]) // RULE_06
    else $error("signed mode not set");
  ap_mem_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    (clk_en && st_q == mie_pkg::ST_WRITE && op == mie_pkg::OP_AP_DM)
    |=> ap_q[$past(asel)] == $past(dm_rdata[5:0])) // RULE_07
    else $error("pointer load wrong");
  zero_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    (clk_en && st_q == mie_pkg::ST_WRITE && op == mie_pkg::OP_ACC_IMM)
    |=> stat_q[mie_pkg::STAT_ZF_BIT] == ($past(imm) == 16'h0000)) // RULE_02
    else $error("zero flag wrong");
  flags_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    (clk_en && st_q == mie_pkg::ST_WRITE && op == mie_pkg::OP_PH_DM)
    |=> $stable(stat_q)) // RULE_23
    else $error("flags changed");
  test_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    (clk_en && st_q == mie_pkg::ST_WRITE && op == mie_pkg::OP_TF_COND)
    |=> stat_q[mie_pkg::STAT_TF1_BIT] == $past(test_condition)) // RULE_14
    else $error("test flag wrong");
  pm_copy_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    (clk_en && st_q == mie_pkg::ST_WRITE && op == mie_pkg::OP_DM_PM)
    |=> dm_write && dm_wdata == $past(pm_rdata)) // RULE_17
    else $error("program copy wrong");
  str_imm_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    (clk_en && st_q == mie_pkg::ST_WRITE && op == mie_pkg::OP_STR_IMM)
    |=> str_q == $past(imm[7:0])) // RULE_12
    else $error("string length wrong");
  pre_inc_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    (clk_en && wr_hit && avs_address == mie_pkg::REG_CMD &&
     avs_byteenable == 4'hF && avs_writedata[8:7] == mie_pkg::PRE_INC)
    |=> ptr_q == $past(ap_q[avs_writedata[6:5]]) + 6'h01) // RULE_01
    else $error("preincrement wrong");

endmodule : mie_move_exec

// >>> tb/mie_mem_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Data and program memory seen by the move block
// ****************************************************************
module mie_mem_model (
  input wire logic sys_clk,
  input wire logic [15:0] dm_addr,
  input wire logic dm_read,
  input wire logic dm_write,
  input wire logic [15:0] dm_wdata,
  output logic [15:0] dm_rdata,
  input wire logic [15:0] pm_addr,
  input wire logic pm_read,
  output logic [15:0] pm_rdata
);
  logic [15:0] mem [0:255];
  logic [15:0] rom_word;

  // Preset words used by the bench
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'h0000;
    end
    mem[8'h10] = 16'hABCD;
    mem[8'h11] = 16'hFFFF;
    mem[8'h12] = 16'h1234;
  end

  // Writes land at the clock edge
  always @(posedge sys_clk) begin
    if (dm_write) begin
      mem[dm_addr[7:0]] <= dm_wdata;
    end
  end

  // Read data stands while the strobe is high, inverse when idle
  assign rom_word = pm_addr ^ 16'hA55A; // Table ROM
  assign dm_rdata = dm_read ? mem[dm_addr[7:0]] : ~mem[dm_addr[7:0]];
  assign pm_rdata = pm_read ? rom_word : ~rom_word;
endmodule : mie_mem_model

// >>> tb/tb_mie_move_exec.sv
`timescale 1ns/1ps
module tb_mie_move_exec;
  typedef struct {
    logic [31:0] c;
    logic t;
    logic [7:0] a;
    logic [31:0] m;
    logic [31:0] e;
  } mie_row_t;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] dm_addr, dm_wdata, dm_rdata, pm_addr, pm_rdata;
  logic dm_read, dm_write, pm_read;
  logic [15:0] idx_five = 16'h0030;
  logic cond = 1'b0;
  int n_errors = 0;
  int total_checks = 0;
  logic [31:0] q;
  mie_row_t rows [16];
  logic [5:0] src_x [4] = '{6'h28, 6'h18, 6'h38, 6'h20};
  logic [15:0] src_e [4] = '{16'h0007, 16'h005A, 16'h1234, 16'h4321};

  // ****************************************************************
  // Design and memories
  // ****************************************************************
  mie_move_exec i_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dm_addr(dm_addr),
    .dm_read(dm_read), .dm_write(dm_write), .dm_wdata(dm_wdata),
    .dm_rdata(dm_rdata), .pm_addr(pm_addr), .pm_read(pm_read),
    .pm_rdata(pm_rdata), .index_register_five(idx_five),
    .test_condition(cond)
  );
  mie_mem_model i_mem (
    .sys_clk(sys_clk), .dm_addr(dm_addr), .dm_read(dm_read),
    .dm_write(dm_write), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata),
    .pm_addr(pm_addr), .pm_read(pm_read), .pm_rdata(pm_rdata)
  );

  // Clock at 125 MHz
  always #4 sys_clk = ~sys_clk;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] mk(input logic [4:0] op,
      input logic [1:0] ac, input logic [15:0] im, input logic [5:0] x);
    return {im, 3'h0, x, ac, op};
  endfunction : mk

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask : check

  // Avalon cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 50) begin
      n_errors++;
      $display("BAD %0t bus never answered", $time);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  // Issue one move and poll until it is done
  task automatic run(input logic [31:0] c, input logic t);
    int n;
    n = 0;
    cond <= t;
    bus(1'b1, mie_pkg::REG_CMD, c);
    q = 32'h0002_0000;
    while (q[17] !== 1'b0 && n < 20) begin
      bus(1'b0, mie_pkg::REG_STATUS, 32'h0000_0000);
      n++;
    end
    if (n >= 20) begin
      n_errors++;
      $display("BAD %0t move never finished", $time);
    end
  endtask : run

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    $display("BAD %0t run hung", $time);
    end_sim();
  end

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    rows = '{
      '{mk(mie_pkg::OP_MR_IMM, 2'h0, 16'hBEEF, 6'h00), 1'b0,
        mie_pkg::REG_MR, 32'h0000_FFFF, 32'h0000_BEEF},
      '{mk(mie_pkg::OP_SV_DM, 2'h0, 16'h0010, 6'h00), 1'b0,
        mie_pkg::REG_SV, 32'h0000_000F, 32'h0000_000D},
      '{mk(mie_pkg::OP_STR_DM, 2'h0, 16'h0010, 6'h00), 1'b0,
        mie_pkg::REG_STR, 32'h0000_00FF, 32'h0000_00CD},
      '{mk(mie_pkg::OP_STR_IMM, 2'h0, 16'h005A, 6'h00), 1'b0,
        mie_pkg::REG_STR, 32'h0000_00FF, 32'h0000_005A},
      '{mk(mie_pkg::OP_SV_IMM, 2'h0, 16'h0009, 6'h00), 1'b0,
        mie_pkg::REG_SV, 32'h0000_000F, 32'h0000_0009},
      '{mk(mie_pkg::OP_AP_DM, 2'h1, 16'h0011, 6'h00), 1'b0,
        mie_pkg::REG_AP, 32'h0000_FF00, 32'h0000_3F00},
      '{mk(mie_pkg::OP_AP_IMM, 2'h2, 16'h0017, 6'h00), 1'b0,
        mie_pkg::REG_AP, 32'h00FF_0000, 32'h0017_0000},
      '{mk(mie_pkg::OP_NOP, 2'h2, 16'h0000, 6'h02), 1'b0,
        mie_pkg::REG_AP, 32'h00FF_0000, 32'h0016_0000},
      '{mk(mie_pkg::OP_TOS_DM, 2'h0, 16'h0012, 6'h00), 1'b0,
        mie_pkg::REG_TOS, 32'h0000_FFFF, 32'h0000_1234},
      '{mk(mie_pkg::OP_STAT_DM, 2'h0, 16'h0011, 6'h00), 1'b0,
        mie_pkg::REG_STATUS, 32'h0000_FFFF, 32'h0000_FFFF},
      '{mk(mie_pkg::OP_MR_DM, 2'h0, 16'h0012, 6'h00), 1'b0,
        mie_pkg::REG_STATUS, 32'h0000_0002, 32'h0000_0000},
      '{mk(mie_pkg::OP_PH_DM, 2'h0, 16'h0012, 6'h00), 1'b0,
        mie_pkg::REG_PH, 32'h0000_FFFF, 32'h0000_1234},
      '{mk(mie_pkg::OP_NOP, 2'h0, 16'h0000, 6'h00), 1'b0,
        mie_pkg::REG_MR, 32'h0000_FFFF, 32'h0000_1234},
      '{mk(mie_pkg::OP_TF_COND, 2'h0, 16'h0000, 6'h00), 1'b1,
        mie_pkg::REG_STATUS, 32'h0000_0008, 32'h0000_0008},
      '{mk(mie_pkg::OP_TF_COND, 2'h0, 16'h0000, 6'h00), 1'b0,
        mie_pkg::REG_STATUS, 32'h0000_0008, 32'h0000_0000},
      '{mk(mie_pkg::OP_TF_FLAG, 2'h0, 16'h0010, 6'h00), 1'b0,
        mie_pkg::REG_STATUS, 32'h0000_0008, 32'h0000_0008}};
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    // Table of single moves, each read back
    foreach (rows[i]) begin
      run(rows[i].c, rows[i].t);
      rd(rows[i].a);
      check(q & rows[i].m, rows[i].e);
    end
    // Premodified load into the pair, zero flag on both halves
    run(mk(mie_pkg::OP_AP_IMM, 2'h0, 16'h0005, 6'h00), 1'b0);
    run(mk(mie_pkg::OP_ACC_IMM, 2'h0, 16'h00F7, 6'h05), 1'b0);
    rd(mie_pkg::REG_AP);
    check(q & 32'h0000_00FF, 32'h0000_0006);
    rd(mie_pkg::REG_STATUS);
    check(q & 32'h0000_0001, 32'h0000_0000);
    run(mk(mie_pkg::OP_ACC_IMM, 2'h0, 16'h0000, 6'h00), 1'b0);
    rd(mie_pkg::REG_STATUS);
    check(q & 32'h0000_0001, 32'h0000_0001);
    run(mk(mie_pkg::OP_AP_IMM, 2'h1, 16'h0003, 6'h00), 1'b0);
    rd(mie_pkg::REG_STATUS);
    check(q & 32'h0000_0001, 32'h0000_0001);
    // Pair copy, then store from the updated pointer
    run(mk(mie_pkg::OP_ACC_PAIR, 2'h0, 16'h0000, 6'h00), 1'b0);
    run(mk(mie_pkg::OP_DM_ACC, 2'h0, 16'h0020, 6'h00), 1'b0);
    check({16'h0000, i_mem.mem[8'h20]}, 32'h0000_00F7);
    // Accumulator into multiplier and shift amount
    run(mk(mie_pkg::OP_STAT_DM, 2'h0, 16'h0011, 6'h00), 1'b0);
    run(mk(mie_pkg::OP_MR_ACC, 2'h0, 16'h0000, 6'h00), 1'b0);
    rd(mie_pkg::REG_MR);
    check(q & 32'h0000_FFFF, 32'h0000_00F7);
    rd(mie_pkg::REG_STATUS);
    check(q & 32'h0000_0002, 32'h0000_0000);
    run(mk(mie_pkg::OP_SV_ACC, 2'h0, 16'h0000, 6'h00), 1'b0);
    rd(mie_pkg::REG_SV);
    check(q & 32'h0000_000F, 32'h0000_0007);
    // Table lookups through program memory
    run(mk(mie_pkg::OP_ACC_PM, 2'h0, 16'h0000, 6'h00), 1'b0);
    run(mk(mie_pkg::OP_DM_ACC, 2'h0, 16'h0021, 6'h00), 1'b0);
    check({16'h0000, i_mem.mem[8'h21]}, 32'h0000_A5AD);
    run(mk(mie_pkg::OP_DM_PM, 2'h0, 16'h0022, 6'h00), 1'b0);
    check({16'h0000, i_mem.mem[8'h22]}, 32'h0000_00F7);
    // Reverse pair copy, read back through the pair
    run(mk(mie_pkg::OP_ACC_PAIR, 2'h0, 16'h0000, 6'h04), 1'b0);
    run(mk(mie_pkg::OP_DM_ACC, 2'h0, 16'h0027, 6'h04), 1'b0);
    check({16'h0000, i_mem.mem[8'h27]}, 32'h0000_A5AD);
    // Special stores: shift amount, string length, stack top, DP
    bus(1'b1, mie_pkg::REG_DP, 32'h0000_4321);
    for (int i = 0; i < 4; i++) begin
      run(mk(mie_pkg::OP_DM_SPECIAL, 2'h0, 16'h0023 + 16'(i), src_x[i]),
          1'b0);
      check({16'h0000, i_mem.mem[8'h23 + 8'(i)]}, {16'h0000, src_e[i]});
    end
    // Test flag stored at index plus offset
    run(mk(mie_pkg::OP_TF_COND, 2'h0, 16'h0000, 6'h00), 1'b1);
    run(mk(mie_pkg::OP_FLAG_TF, 2'h0, 16'h0004, 6'h00), 1'b0);
    check({31'h0, i_mem.mem[8'h34][0]}, 32'h0000_0001);
    // Unmapped read, then a second reset
    rd(8'hFC);
    check(q, {16'h0000, mie_pkg::UNMAPPED_RD});
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(mie_pkg::REG_MR);
    check(q & 32'h0000_FFFF, {16'h0000, mie_pkg::WORD_RST});
    end_sim();
  end
endmodule : tb_mie_move_exec
